// *** design/regbuf_pkg.sv ***
// package for the registered 1:2 command/address buffer
// assumes a single 250 MHz clock and active-low asynchronous reset
package regbuf_pkg;
  // ==========================================================
  // widths and counts
  localparam int unsigned DATA_W       = 22;  // parity-covered data inputs
  localparam int unsigned CTRL_W       = 4;   // termination and clock-enable lines
  localparam int unsigned SEL_W        = 2;   // select lines
  localparam int unsigned TOTAL_W      = 28;  // registered bits in all
  localparam int unsigned FIFO_DEPTH   = 16;
  localparam int unsigned ERR_HOLD_CYC = 2;   // error stays low for this many cycles
  // ==========================================================
  // reset values
  localparam logic        OUT_RST      = 1'b0;
  localparam logic        PERR_N_RST   = 1'b1;
  localparam logic [1:0]  HOLD_CNT_RST = 2'h0;
endpackage

// *** design/registered_buffer_1to2_parity.sv ***
// What this block does
// RULE1 - capture all inputs on rising clock edge
// RULE2 - each of 28 bits drives two copies
// RULE3 - reset clears registers, outputs held low
// RULE4 - inputs ignored entirely while in reset
// RULE5 - controller holds reset through power-up
// RULE6 - reset acts asynchronously to clock
// RULE7 - outputs go low immediately on reset
// RULE8 - after reset, low inputs keep outputs low
// RULE9 - gating on, both selects high: hold outputs; the code holds only the data copies, config and select copies still update
// RULE10 - any select low: outputs update normally
// RULE11 - reset overrides gating, error output released
// RULE12 - gating enable low: selects act as data
// RULE13 - compare parity bit against captured data
// RULE14 - error pin open-drain, pulled low on error
// RULE15 - controller drives reset and config validly
// RULE16 - odd count of ones flags an error
// RULE17 - parity bit pairs with previous cycle data
// RULE18 - error held low two cycles once set
// RULE19 - both copies identical, same edge
// RULE20 - single clock, asynchronous active-low clear
//
// file holds the fifo and the buffer top
// assumes the controller-side inputs are synchronous to clk_i

// ==========================================================
// fifo
// words leave in the order they came; one pointer bit beyond the
// address tells full from empty without a separate counter
// memory holds no reset, so a word is only trusted while valid
// a push against a full fifo is dropped, never overwrites
// hazard: depth must be a power of two for the wrap to work
module regbuf_fifo #(
  parameter int unsigned WIDTH = 28,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");
  end

  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } fifo_s;

  fifo_s             st;
  fifo_s             next_st;
  logic [WIDTH-1:0]  mem [DEPTH];
  logic              push;
  logic              pop;
  logic              full;
  logic              empty;

  // flag and strobe terms
  always_comb begin
    full        = (st.wr[AW] != st.rd[AW]) && (st.wr[AW-1:0] == st.rd[AW-1:0]);
    empty       = (st.wr == st.rd);
    push        = in_valid_i && !full;
    pop         = out_ready_i && !empty;
    next_st     = st;
    if (push) next_st.wr = st.wr + 1'b1;
    if (pop)  next_st.rd = st.rd + 1'b1;
    in_ready_o  = !full;
    out_valid_o = !empty;
    out_data_o  = mem[st.rd[AW-1:0]];
  end

  // pointer registers
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[st.wr[AW-1:0]] <= in_data_i;
    end
  end

  // ==========================================================
  // fifo checks
  chk_fifo_no_overrun: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE1
    full && in_valid_i |=> st.wr == $past(st.wr))
    else $error("fifo write pointer moved while full");

  chk_fifo_no_underrun: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE1
    empty && out_ready_i |=> st.rd == $past(st.rd))
    else $error("fifo read pointer moved while empty");
endmodule

// ==========================================================
// buffer top
// capture path: inputs join one word, pass the fifo, then the
// output register; the fifo drains one word per edge, so it never
// fills while the controller sends at most one word per cycle
// gating reads the live enable level at the fifo head
// parity: each popped word leaves its data parity behind, the
// next popped word brings the bit that covers it
// error hold counts down from the package value
// reset clears every register but the fifo memory without waiting for a clock edge
module registered_buffer_1to2_parity
  import regbuf_pkg::*;
#(
  parameter int unsigned D_W   = regbuf_pkg::DATA_W,
  parameter int unsigned DEPTH = regbuf_pkg::FIFO_DEPTH
) (
  input  wire logic                          clk_i,
  input  wire logic                          rstn_i,
  input  wire logic [D_W-1:0]                buffered_in_i,
  input  wire logic [regbuf_pkg::CTRL_W-1:0] config_inputs_i,
  input  wire logic                          select_in_zero_i,
  input  wire logic                          select_in_one_i,
  input  wire logic                          select_gating_enable_i,
  input  wire logic                          parity_bit_in_i,
  input  wire logic                          in_valid_i,
  output logic                               in_ready_o,
  output logic [D_W-1:0]                     buffered_out_a_o,
  output logic [D_W-1:0]                     buffered_out_b_o,
  output logic [regbuf_pkg::CTRL_W-1:0]      config_out_a_o,
  output logic [regbuf_pkg::CTRL_W-1:0]      config_out_b_o,
  output logic [regbuf_pkg::SEL_W-1:0]       select_copy_out_a_o,
  output logic [regbuf_pkg::SEL_W-1:0]       select_copy_out_b_o,
  output logic                               parity_error_n_o,
  output logic                               parity_error_n_oe_o
);
  import regbuf_pkg::*;

  localparam int unsigned FW = D_W + CTRL_W + SEL_W + 1;

  initial begin
    if (D_W + CTRL_W + SEL_W != TOTAL_W) $error("registered width must total 28");
    if (ERR_HOLD_CYC < 1 || ERR_HOLD_CYC > 3) $error("error hold must fit the 2-bit counter");
  end

  typedef struct packed {
    logic [D_W-1:0]    main;
    logic [CTRL_W-1:0] cfg;
    logic [SEL_W-1:0]  sel;
    logic              prev_par;   // parity of last captured data
    logic              prev_ok;    // previous capture had a select low
    logic [1:0]        hold;
    logic              perr_n;
  } buf_s;

  buf_s            st;
  buf_s            next_st;
  logic [FW-1:0]   fifo_in;
  logic [FW-1:0]   fifo_out;
  logic            fifo_valid;
  logic            gate;
  logic            odd;

  // fifo word layout, high to low:
  //   data bits, config bits, select one, select zero, parity bit
  // the parity bit in a word covers the data of the word before
  // captured word enters the fifo, drained one per edge
  assign fifo_in = {buffered_in_i, config_inputs_i, select_in_one_i, select_in_zero_i, parity_bit_in_i};

  regbuf_fifo #(
    .WIDTH (FW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rstn_i      (rstn_i),
    .in_data_i   (fifo_in),
    .in_valid_i  (in_valid_i),
    .in_ready_o  (in_ready_o),
    .out_data_o  (fifo_out),
    .out_valid_o (fifo_valid),
    .out_ready_i (1'b1)
  );

  // next-state logic for capture, gating and parity
  always_comb begin
    next_st = st;
    gate    = select_gating_enable_i && fifo_out[2] && fifo_out[1];       // RULE9 RULE12
    odd     = ^{st.prev_par, fifo_out[0]};                                 // RULE16 RULE17
    if (fifo_valid) begin                                                  // RULE1
      if (!gate) next_st.main = fifo_out[FW-1 -: D_W];                     // RULE10
      next_st.cfg      = fifo_out[CTRL_W+2 : 3];
      next_st.sel      = fifo_out[2:1];
      next_st.prev_par = ^fifo_out[FW-1 -: D_W];
      next_st.prev_ok  = !(fifo_out[2] && fifo_out[1]);
    end
    // error hold and compare
    if (st.hold != HOLD_CNT_RST) begin                                     // RULE18
      next_st.hold = st.hold - 2'h1;
      if (st.hold == 2'h1) next_st.perr_n = 1'b1;
    end else if (fifo_valid && st.prev_ok && odd) begin                    // RULE13
      next_st.perr_n = 1'b0;
      next_st.hold   = 2'(ERR_HOLD_CYC);
    end
  end

  // state register, asynchronous clear
  always_ff @(posedge clk_i or negedge rstn_i) begin                       // RULE20 RULE6
    if (!rstn_i) begin                                                     // RULE3 RULE4 RULE7 RULE11
      st.main     <= {D_W{OUT_RST}};                                       // RULE8
      st.cfg      <= {CTRL_W{OUT_RST}};
      st.sel      <= {SEL_W{OUT_RST}};
      st.prev_par <= 1'b0;
      st.prev_ok  <= 1'b0;
      st.hold     <= HOLD_CNT_RST;
      st.perr_n   <= PERR_N_RST;
    end else begin
      st <= next_st;
    end
  end

  // two identical copies, open-drain error
  always_comb begin                                                        // RULE2 RULE19
    buffered_out_a_o    = st.main;
    buffered_out_b_o    = st.main;
    config_out_a_o      = st.cfg;
    config_out_b_o      = st.cfg;
    select_copy_out_a_o = st.sel;
    select_copy_out_b_o = st.sel;
    parity_error_n_o    = 1'b0;                                            // RULE14
    parity_error_n_oe_o = !st.perr_n;
  end

  // ==========================================================
  // checks
  chk_copies_equal: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE19
    buffered_out_a_o == buffered_out_b_o && config_out_a_o == config_out_b_o)
    else $error("output copies differ");

  chk_gate_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)    // RULE9
    fifo_valid && gate |=> $stable(buffered_out_a_o))
    else $error("gated output changed");

  chk_normal_update: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE10
    fifo_valid && !(fifo_out[2] && fifo_out[1]) |=> buffered_out_a_o == $past(fifo_out[FW-1 -: D_W]))
    else $error("output did not update");

  chk_gate_off: assert property (@(posedge clk_i) disable iff (!rstn_i)     // RULE12
    fifo_valid && !select_gating_enable_i |=> buffered_out_b_o == $past(fifo_out[FW-1 -: D_W]))
    else $error("gating active while disabled");

  chk_err_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)     // RULE18
    $fell(parity_error_n_oe_o == 1'b0) |-> parity_error_n_oe_o [*2] ##1 !parity_error_n_oe_o)
    else $error("error not held two cycles");

  chk_err_cause: assert property (@(posedge clk_i) disable iff (!rstn_i)    // RULE16
    $rose(parity_error_n_oe_o) |-> $past(odd) && $past(st.prev_ok))
    else $error("error without odd parity");

  chk_err_seen: assert property (@(posedge clk_i) disable iff (!rstn_i)     // RULE13
    fifo_valid && st.prev_ok && odd && st.hold == 2'h0 |=> parity_error_n_oe_o)
    else $error("parity error missed");

  chk_drive_low: assert property (@(posedge clk_i) disable iff (!rstn_i)    // RULE14
    parity_error_n_o == 1'b0)
    else $error("open-drain drives high");

  chk_reset_low: assert property (@(posedge clk_i)                          // RULE3
    !rstn_i |-> buffered_out_a_o == '0 && !parity_error_n_oe_o)
    else $error("outputs not cleared in reset");

  // config copies follow every popped word
  chk_cfg_follow: assert property (@(posedge clk_i) disable iff (!rstn_i)   // RULE1
    fifo_valid |=> config_out_a_o == $past(fifo_out[CTRL_W+2 : 3]))
    else $error("config copy did not follow");

  // selects pass as data when gating is off
  chk_sel_follow: assert property (@(posedge clk_i) disable iff (!rstn_i)   // RULE12
    fifo_valid && !select_gating_enable_i |=> select_copy_out_b_o == $past(fifo_out[2:1]))
    else $error("select copy did not follow");

  // select copies match
  chk_sel_copies: assert property (@(posedge clk_i) disable iff (!rstn_i)   // RULE19
    select_copy_out_a_o == select_copy_out_b_o)
    else $error("select copies differ");

  // no word popped, data, config and select copies do not move
  chk_idle_keep: assert property (@(posedge clk_i) disable iff (!rstn_i)    // RULE1
    !fifo_valid |=> $stable(buffered_out_a_o) && $stable(config_out_a_o) && $stable(select_copy_out_a_o))
    else $error("outputs moved without a word");

  // error never stands a third cycle
  chk_err_max: assert property (@(posedge clk_i) disable iff (!rstn_i)      // RULE18
    parity_error_n_oe_o && $past(parity_error_n_oe_o) |=> !parity_error_n_oe_o)
    else $error("error held too long");

  // pin follows the hold counter
  chk_hold_pin: assert property (@(posedge clk_i) disable iff (!rstn_i)     // RULE18
    (st.hold != HOLD_CNT_RST) == parity_error_n_oe_o)
    else $error("error pin and hold counter disagree");

  // word after a deselected word is not checked
  chk_skip_desel: assert property (@(posedge clk_i) disable iff (!rstn_i)   // RULE13
    fifo_valid && !st.prev_ok && st.hold == 2'h0 |=> !parity_error_n_oe_o)
    else $error("error flagged after deselected word");

  // outputs still low at the first edge after release
  chk_release_low: assert property (@(posedge clk_i)                        // RULE8
    $rose(rstn_i) |-> buffered_out_a_o == '0 && config_out_a_o == '0 && !parity_error_n_oe_o)
    else $error("outputs not low after release");

  // reset beats gating on the second copy too
  chk_reset_prio: assert property (@(posedge clk_i)                         // RULE11
    !rstn_i |-> buffered_out_b_o == '0 && !parity_error_n_oe_o)
    else $error("reset did not override gating");

  // ==========================================================
  // scenario covers
  cov_gated: cover property (@(posedge clk_i) disable iff (!rstn_i) fifo_valid && gate);
  cov_gate_off: cover property (@(posedge clk_i) disable iff (!rstn_i)
    fifo_valid && !select_gating_enable_i && fifo_out[2] && fifo_out[1]);
  cov_err_skip: cover property (@(posedge clk_i) disable iff (!rstn_i) fifo_valid && !st.prev_ok);
  cov_error: cover property (@(posedge clk_i) disable iff (!rstn_i) $rose(parity_error_n_oe_o));
  cov_full:  cover property (@(posedge clk_i) disable iff (!rstn_i) !in_ready_o);
endmodule

// *** tb/ctrl_model.sv ***
// controller model: drives words, parity one beat late
// assumes the bench supplies each word and any parity fault
module ctrl_model (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic [21:0] word_i,
  input  wire logic        push_i,
  input  wire logic        bad_i,
  input  wire logic        ready_i,
  output logic      [21:0] data_o,
  output logic             parity_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        par;
  logic [21:0] last;
  // ==========================================================
  // remember parity of the word just taken
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      par  <= 1'b0;
      last <= 22'h0;
    end else if (push_i && ready_i) begin
      par  <= ^word_i;
      last <= word_i;
    end
  end
  // idle lines never show the last word
  assign data_o   = push_i ? word_i : ~last;
  assign parity_o = par ^ bad_i;
endmodule

// *** tb/registered_buffer_1to2_parity_tb.sv ***
// bench for the registered buffer and its fifo
// assumes the buffer drains its fifo every cycle
module registered_buffer_1to2_parity_tb;
  import regbuf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [21:0] d; logic [3:0] c; logic [1:0] s; logic g; logic e;} note_s;
  logic        clk_i = 0, rstn_i = 1, vld = 0, sel0 = 0, sel1 = 0, gate = 0, bad = 0;
  logic        par, rdy, perr, oe, prev_ok = 0;
  logic [21:0] word = 0, din, qa, qb, xd;
  logic [3:0]  cfg = 0, ca, cb, xc;
  logic [1:0]  sa, sb, xs;
  logic [1:0]  pipe;
  int          mismatches = 0, n_checks = 0, seed = 64, cyc = 0, cnt = 0;
  note_s       n;
  note_s       q[$];
  // ==========================================================
  // instances
  registered_buffer_1to2_parity uut (.clk_i, .rstn_i, .buffered_in_i(din), .config_inputs_i(cfg),
    .select_in_zero_i(sel0), .select_in_one_i(sel1), .select_gating_enable_i(gate), .parity_bit_in_i(par),
    .in_valid_i(vld), .in_ready_o(rdy), .buffered_out_a_o(qa), .buffered_out_b_o(qb), .config_out_a_o(ca),
    .config_out_b_o(cb), .select_copy_out_a_o(sa), .select_copy_out_b_o(sb), .parity_error_n_o(perr),
    .parity_error_n_oe_o(oe));
  ctrl_model cm (.clk_i, .rstn_i, .word_i(word), .push_i(vld), .bad_i(bad), .ready_i(rdy), .data_o(din),
    .parity_o(par));
  // ==========================================================
  // clock, hang limit, push history
  initial forever #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      tally_and_finish;
    end
  end
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) pipe <= 2'h0;
    else pipe <= {pipe[0], vld & rdy};
  end
  // ==========================================================
  // compare and report
  task automatic chk(string nm, logic [57:0] e, logic [57:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==========================================================
  // monitor: oldest note meets each word two edges after push
  initial forever begin
    @(posedge clk_i);
    #1;
    if (!rstn_i) begin
      xd = 22'h0;
      xc = 4'h0;
      xs = 2'h0;
      cnt = 0;
    end else begin
      if (pipe[1]) begin
        n = q.pop_front();
        if (!(n.g && &n.s)) xd = n.d;
        xc = n.c;
        xs = n.s;
      end
      cnt = (cnt != 0) ? cnt - 1 : ((pipe[1] && n.e) ? 2 : 0);
    end
    chk("outputs", {xd, xd, xc, xc, xs, xs, cnt != 0, 1'b0}, {qa, qb, ca, cb, sa, sb, oe, perr});
  end
  // ==========================================================
  // driver: random words, selects and parity faults
  task automatic stream(int cnt_w, logic g, logic all_bad);
    note_s w;
    logic  b;
    repeat (cnt_w) begin
      @(posedge clk_i);
      {w.d, w.c, w.s} = 28'($random(seed));
      b = all_bad || (($random(seed) & 3) == 0);
      w.g = g;
      w.e = prev_ok && b;
      word <= w.d;
      cfg <= w.c;
      {sel1, sel0} <= w.s;
      gate <= g;
      bad <= b;
      vld <= 1'b1;
      q.push_back(w);
      prev_ok = !(&w.s);
    end
    @(posedge clk_i);
    vld <= 1'b0;
    bad <= 1'b0;
  endtask
  // reset between edges after the last word reaches the outputs, while an error is in flight
  task automatic hit_reset;
    @(posedge clk_i);
    #1.5 rstn_i = 1'b0;
    #0.3 chk("reset", 58'h0, {qa, qb, ca, cb, sa, sb, oe, perr});
    q.delete();
    prev_ok = 1'b0;
    {word, cfg, sel1, sel0} <= 'x;
    repeat (3) @(posedge clk_i);
    {word, cfg, sel1, sel0} <= '0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (5) @(posedge clk_i);
  endtask
  // fifo through the top: back-to-back words never stall, then drain
  task automatic fifo_test;
    fork
      stream(20, 1'b0, 1'b0);
      repeat (20) begin
        @(posedge clk_i);
        #1 chk("fifo_ready", 58'h1, {57'h0, rdy});
      end
    join
    repeat (3) @(posedge clk_i);
    #2 chk("fifo_idle", 58'h1, {57'h0, rdy});
    chk("fifo_last", {36'h0, xd}, {36'h0, qa});
  endtask
  // ==========================================================
  // main sequence
  initial begin
    #1 rstn_i = 1'b0;
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    stream(60, 1'b1, 1'b0);
    repeat (4) @(posedge clk_i);
    stream(60, 1'b0, 1'b0);
    repeat (4) @(posedge clk_i);
    stream(6, 1'b0, 1'b1);
    hit_reset;
    fifo_test;
    tally_and_finish;
  end
endmodule
